/* rtl/fp_cfg_pkg.sv */
// Shared constants and types for the floating-point configuration and status registers
package fp_cfg_pkg;

  // Register select codes on the control-register move path
  localparam logic [1:0] SEL_ADDER = 2'h0;
  localparam logic [1:0] SEL_AUX   = 2'h1;
  localparam logic [1:0] SEL_MUL   = 2'h2;

  // Geometry of one register
  localparam int HALF_W    = 16;
  localparam int EVT_W     = 11;
  localparam int ROUND_LSB = 9;

  // Field positions inside one half
  localparam int RECIP_ZERO_BIT  = 10;
  localparam int UNORDERED_BIT   = 9;
  localparam int UNDERFLOW_BIT   = 8;
  localparam int INEXACT_BIT     = 7;
  localparam int OVERFLOW_BIT    = 6;
  localparam int INFINITY_BIT    = 5;
  localparam int INVALID_BIT     = 4;
  localparam int SRC2_DENORM_BIT = 3;
  localparam int SRC1_DENORM_BIT = 2;
  localparam int SRC2_NAN_BIT    = 1;
  localparam int SRC1_NAN_BIT    = 0;

  // Writable bits of a half; bits 15 to 11 stay zero
  localparam logic [15:0] HALF_WR_MASK  = 16'h07FF;
  // Bits a unit may set: rounding half versus auxiliary half
  localparam logic [15:0] FLAG_MASK_RND = 16'h01FF;
  localparam logic [15:0] FLAG_MASK_AUX = 16'h07FF;

  // Reset values
  localparam logic [15:0] HALF_RESET = 16'h0000;
  localparam logic [31:0] RD_RESET   = 32'h0000_0000;

  typedef enum logic [1:0] {
    RND_NEAREST = 2'h0,
    RND_ZERO    = 2'h1,
    RND_POS_INF = 2'h2,
    RND_NEG_INF = 2'h3
  } round_t;

  // One flag report from a functional unit; flags use the half's bit layout
  typedef struct packed {
    logic             fire;
    logic             condTrue;
    logic             addSub;
    logic [EVT_W-1:0] flags;
  } fp_event_t;

endpackage

/* rtl/fp_half_reg.sv */
// One 16-bit half of a configuration and status register
`timescale 1ns/10ps
module fp_half_reg #(
  parameter logic [15:0] WR_MASK = fp_cfg_pkg::HALF_WR_MASK
) (
  // Clock, reset, enable
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // Software write
  input  wire logic        wrEn,
  input  wire logic [15:0] wrData,
  // Unit flag reports
  input  wire logic [15:0] setBits,
  // Stored value
  output logic      [15:0] value_reg
);

  logic [15:0] value_next;

  // Unit reports are ORed after the write, so a same-cycle event is never lost
  always_comb begin
    value_next = wrEn ? (wrData & WR_MASK) : value_reg;
    value_next = value_next | (setBits & WR_MASK);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      value_reg <= fp_cfg_pkg::HALF_RESET;
    end else if (ce) begin
      value_reg <= value_next;
    end
  end

endmodule // fp_half_reg

/* rtl/fp_unit_config_status_regs.sv */
// Adder, auxiliary and multiplier floating-point configuration and status registers
`timescale 1ns/10ps
module fp_unit_config_status_regs (
  // Clock, reset, enable
  input  wire logic                          clock,
  input  wire logic                          arst_n,
  input  wire logic                          ce,
  // Control-register move path
  input  wire logic                          wrEn,
  input  wire logic [1:0]                    wrSel,
  input  wire logic [31:0]                   wrData,
  input  wire logic                          rdEn,
  input  wire logic [1:0]                    rdSel,
  output logic      [31:0]                   rdData,
  output logic                               rdValid,
  // Unit flag reports, index 0 is side 1
  input  wire fp_cfg_pkg::fp_event_t [1:0]   adderEvt,
  input  wire fp_cfg_pkg::fp_event_t [1:0]   auxEvt,
  input  wire fp_cfg_pkg::fp_event_t [1:0]   mulEvt,
  // Rounding selects to the units
  output fp_cfg_pkg::round_t [1:0]           adderRound,
  output fp_cfg_pkg::round_t [1:0]           auxAddRound,
  output fp_cfg_pkg::round_t [1:0]           mulRound
);

  logic [2:0][1:0][15:0] halfVal;
  logic [2:0][1:0][15:0] setBits;
  logic [31:0]           rdData_reg;
  logic [31:0]           rdData_next;
  logic                  rdValid_reg;

  // Qualified flags of one report; false-condition reports set nothing
  function automatic logic [15:0] evt_bits(fp_cfg_pkg::fp_event_t e,
                                           logic [15:0] mask);
    logic [15:0] b;
    b = 16'h0000;
    if (e.fire && e.condTrue) begin
      b = {5'h00, e.flags} & mask;
    end
    if (b[fp_cfg_pkg::INVALID_BIT]) begin
      b[fp_cfg_pkg::INEXACT_BIT] = 1'b0;
    end
    return b;
  endfunction

  function automatic logic sel_hit(logic en, logic [1:0] sel, logic [1:0] code);
    return en && (sel == code);
  endfunction

  // Routing of unit reports into register halves
  always_comb begin
    setBits = '0;
    for (int s = 0; s < 2; s++) begin
      setBits[fp_cfg_pkg::SEL_ADDER][s] = evt_bits(adderEvt[s],
                                                   fp_cfg_pkg::FLAG_MASK_RND);
      setBits[fp_cfg_pkg::SEL_MUL][s] = evt_bits(mulEvt[s],
                                                 fp_cfg_pkg::FLAG_MASK_RND);
      if (auxEvt[s].addSub) begin
        setBits[fp_cfg_pkg::SEL_ADDER][s] = setBits[fp_cfg_pkg::SEL_ADDER][s]
          | evt_bits(auxEvt[s], fp_cfg_pkg::FLAG_MASK_RND);
      end else begin
        setBits[fp_cfg_pkg::SEL_AUX][s] = evt_bits(auxEvt[s],
                                                   fp_cfg_pkg::FLAG_MASK_AUX);
      end
    end
  end

  // Denormal and NaN source bits travel in the low flag positions
  // of every report and are stored like the other warnings.
  for (genvar r = 0; r < 3; r++) begin : gReg
    for (genvar s = 0; s < 2; s++) begin : gHalf
      fp_half_reg #(
        .WR_MASK (fp_cfg_pkg::HALF_WR_MASK)
      ) uHalf (
        .clock     (clock),
        .arst_n    (arst_n),
        .ce        (ce),
        .wrEn      (sel_hit(wrEn, wrSel, 2'(r))),
        .wrData    (wrData[s*16 +: 16]),
        .setBits   (setBits[r][s]),
        .value_reg (halfVal[r][s])
      );
    end
  end

  // Rounding selects come straight from the stored fields
  for (genvar s = 0; s < 2; s++) begin : gRound
    assign adderRound[s] = fp_cfg_pkg::round_t'(
      halfVal[fp_cfg_pkg::SEL_ADDER][s][fp_cfg_pkg::ROUND_LSB +: 2]);
    // Auxiliary add and subtract share the adder select, not a field of their own
    assign auxAddRound[s] = fp_cfg_pkg::round_t'(
      halfVal[fp_cfg_pkg::SEL_ADDER][s][fp_cfg_pkg::ROUND_LSB +: 2]);
    assign mulRound[s] = fp_cfg_pkg::round_t'(
      halfVal[fp_cfg_pkg::SEL_MUL][s][fp_cfg_pkg::ROUND_LSB +: 2]);
  end

  // Read path; registered, so a write shows one cycle after its edge
  always_comb begin
    rdData_next = 32'h0000_0000;
    if (rdSel != 2'h3) begin
      rdData_next = {halfVal[rdSel][1], halfVal[rdSel][0]};
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdData_reg <= fp_cfg_pkg::RD_RESET;
    end else if (ce && rdEn) begin
      rdData_reg <= rdData_next;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdValid_reg <= 1'b0;
    end else if (ce) begin
      rdValid_reg <= rdEn;
    end
  end

  assign rdData  = rdData_reg;
  assign rdValid = rdValid_reg;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  logic anyTrueEvt;
  logic anyAdderSet;
  always_comb begin
    anyTrueEvt  = 1'b0;
    anyAdderSet = 1'b0;
    for (int s = 0; s < 2; s++) begin
      anyTrueEvt = anyTrueEvt | (adderEvt[s].fire & adderEvt[s].condTrue)
                 | (auxEvt[s].fire & auxEvt[s].condTrue)
                 | (mulEvt[s].fire & mulEvt[s].condTrue);
      anyAdderSet = anyAdderSet | (adderEvt[s].fire & adderEvt[s].condTrue)
                  | (auxEvt[s].fire & auxEvt[s].condTrue & auxEvt[s].addSub);
    end
  end

  sequence auxWrite_s;
    ce && wrEn && wrSel == fp_cfg_pkg::SEL_AUX && !anyTrueEvt;
  endsequence

  sequence auxRead_s;
    ce && rdEn && rdSel == fp_cfg_pkg::SEL_AUX && !wrEn && !anyTrueEvt;
  endsequence

  reserved_read_zero_a: assert property (
    rdValid |-> (rdData[31:27] == 5'h00 && rdData[15:11] == 5'h00))
    else $error("reserved bits read nonzero");

  aux_write_read_a: assert property (
    auxWrite_s ##1 auxRead_s |=> rdData == ($past(wrData, 2) & 32'h07FF_07FF))
    else $error("auxiliary register readback mismatch");

  round_write_a: assert property (
    ce && wrEn && wrSel == fp_cfg_pkg::SEL_MUL
      |=> mulRound[1] == fp_cfg_pkg::round_t'($past(wrData[26:25])))
    else $error("rounding select not taken from write");

  aux_uses_adder_a: assert property (
    ce && wrEn && wrSel == fp_cfg_pkg::SEL_ADDER && !anyTrueEvt
      |=> auxAddRound[0] == fp_cfg_pkg::round_t'($past(wrData[10:9])))
    else $error("auxiliary add rounding not from adder register");

  cond_false_hold_a: assert property (
    ce && !wrEn && !anyTrueEvt |=> $stable(halfVal))
    else $error("flags changed without a true report");

  sticky_flag_a: assert property (
    halfVal[fp_cfg_pkg::SEL_ADDER][0][fp_cfg_pkg::UNDERFLOW_BIT]
      && !(wrEn && wrSel == fp_cfg_pkg::SEL_ADDER)
      |=> halfVal[fp_cfg_pkg::SEL_ADDER][0][fp_cfg_pkg::UNDERFLOW_BIT])
    else $error("sticky flag lost");

  set_beats_write_a: assert property (
    ce && wrEn && wrSel == fp_cfg_pkg::SEL_MUL && mulEvt[0].fire && mulEvt[0].condTrue
      && mulEvt[0].flags[fp_cfg_pkg::OVERFLOW_BIT]
      |=> halfVal[fp_cfg_pkg::SEL_MUL][0][fp_cfg_pkg::OVERFLOW_BIT])
    else $error("unit set lost under software write");

  addsub_to_adder_a: assert property (
    ce && auxEvt[1].fire && auxEvt[1].condTrue && auxEvt[1].addSub
      && auxEvt[1].flags[fp_cfg_pkg::OVERFLOW_BIT]
      |=> halfVal[fp_cfg_pkg::SEL_ADDER][1][fp_cfg_pkg::OVERFLOW_BIT])
    else $error("auxiliary add warning missing from adder register");

  other_aux_kept_a: assert property (
    ce && !wrEn && !anyAdderSet |=> $stable(halfVal[fp_cfg_pkg::SEL_ADDER]))
    else $error("adder flags changed by non add/subtract report");

  recip_zero_a: assert property (
    ce && auxEvt[0].fire && auxEvt[0].condTrue && !auxEvt[0].addSub
      && auxEvt[0].flags[fp_cfg_pkg::RECIP_ZERO_BIT]
      |=> halfVal[fp_cfg_pkg::SEL_AUX][0][fp_cfg_pkg::RECIP_ZERO_BIT])
    else $error("reciprocal zero flag not set");

  inexact_invalid_a: assert property (
    ce && !wrEn && adderEvt[0].fire && adderEvt[0].condTrue
      && adderEvt[0].flags[fp_cfg_pkg::INVALID_BIT]
      && !halfVal[fp_cfg_pkg::SEL_ADDER][0][fp_cfg_pkg::INEXACT_BIT]
      && !(auxEvt[0].fire && auxEvt[0].condTrue && auxEvt[0].addSub)
      |=> !halfVal[fp_cfg_pkg::SEL_ADDER][0][fp_cfg_pkg::INEXACT_BIT])
    else $error("inexact set together with invalid");

  enable_freeze_a: assert property (
    !ce |=> $stable(halfVal) && $stable(rdData))
    else $error("state moved while enable low");

  unordered_flag_a: assert property (
    ce && auxEvt[1].fire && auxEvt[1].condTrue && !auxEvt[1].addSub
      && auxEvt[1].flags[fp_cfg_pkg::UNORDERED_BIT]
      |=> halfVal[fp_cfg_pkg::SEL_AUX][1][fp_cfg_pkg::UNORDERED_BIT])
    else $error("unordered compare flag not set");

  underflow_flag_a: assert property (
    ce && mulEvt[1].fire && mulEvt[1].condTrue
      && mulEvt[1].flags[fp_cfg_pkg::UNDERFLOW_BIT]
      |=> halfVal[fp_cfg_pkg::SEL_MUL][1][fp_cfg_pkg::UNDERFLOW_BIT])
    else $error("underflow flag not set");

  overflow_flag_a: assert property (
    ce && mulEvt[0].fire && mulEvt[0].condTrue
      && mulEvt[0].flags[fp_cfg_pkg::OVERFLOW_BIT]
      |=> halfVal[fp_cfg_pkg::SEL_MUL][0][fp_cfg_pkg::OVERFLOW_BIT])
    else $error("overflow flag not set");

  infinity_flag_a: assert property (
    ce && mulEvt[1].fire && mulEvt[1].condTrue
      && mulEvt[1].flags[fp_cfg_pkg::INFINITY_BIT]
      |=> halfVal[fp_cfg_pkg::SEL_MUL][1][fp_cfg_pkg::INFINITY_BIT])
    else $error("infinity flag not set");

  invalid_flag_a: assert property (
    ce && auxEvt[0].fire && auxEvt[0].condTrue && !auxEvt[0].addSub
      && auxEvt[0].flags[fp_cfg_pkg::INVALID_BIT]
      |=> halfVal[fp_cfg_pkg::SEL_AUX][0][fp_cfg_pkg::INVALID_BIT])
    else $error("invalid flag not set");

  denormal_src_a: assert property (
    ce && auxEvt[1].fire && auxEvt[1].condTrue && !auxEvt[1].addSub
      && auxEvt[1].flags[fp_cfg_pkg::SRC2_DENORM_BIT]
      |=> halfVal[fp_cfg_pkg::SEL_AUX][1][fp_cfg_pkg::SRC2_DENORM_BIT])
    else $error("denormal source flag not set");

  nan_src_a: assert property (
    ce && auxEvt[0].fire && auxEvt[0].condTrue && !auxEvt[0].addSub
      && auxEvt[0].flags[fp_cfg_pkg::SRC1_NAN_BIT]
      |=> halfVal[fp_cfg_pkg::SEL_AUX][0][fp_cfg_pkg::SRC1_NAN_BIT])
    else $error("nan source flag not set");

  mul_inexact_invalid_a: assert property (
    ce && !wrEn && mulEvt[1].fire && mulEvt[1].condTrue
      && mulEvt[1].flags[fp_cfg_pkg::INVALID_BIT]
      && !halfVal[fp_cfg_pkg::SEL_MUL][1][fp_cfg_pkg::INEXACT_BIT]
      |=> !halfVal[fp_cfg_pkg::SEL_MUL][1][fp_cfg_pkg::INEXACT_BIT])
    else $error("multiplier inexact set together with invalid");

  mul_round_low_a: assert property (
    ce && wrEn && wrSel == fp_cfg_pkg::SEL_MUL
      |=> mulRound[0] == fp_cfg_pkg::round_t'($past(wrData[10:9])))
    else $error("low rounding select not taken from write");

  adder_round_high_a: assert property (
    ce && wrEn && wrSel == fp_cfg_pkg::SEL_ADDER
      |=> adderRound[1] == fp_cfg_pkg::round_t'($past(wrData[26:25])))
    else $error("high adder rounding select not taken from write");

  read_valid_a: assert property (
    ce && rdEn |=> rdValid)
    else $error("read not answered with valid");

  read_idle_a: assert property (
    ce && !rdEn |=> !rdValid)
    else $error("valid without a read");

  read_none_zero_a: assert property (
    ce && rdEn && rdSel == 2'h3 |=> rdData == 32'h0000_0000)
    else $error("unmapped select read nonzero");

  unmapped_write_a: assert property (
    ce && wrEn && wrSel == 2'h3 && !anyTrueEvt |=> $stable(halfVal))
    else $error("unmapped select write changed a register");

  addsub_not_aux_a: assert property (
    ce && !wrEn && auxEvt[1].fire && auxEvt[1].addSub
      |=> $stable(halfVal[fp_cfg_pkg::SEL_AUX][1]))
    else $error("auxiliary add report changed auxiliary register");

  cond_false_aux_a: assert property (
    ce && !wrEn && auxEvt[1].fire && !auxEvt[1].condTrue
      |=> $stable(halfVal[fp_cfg_pkg::SEL_AUX][1]))
    else $error("false condition report changed flags");

endmodule // fp_unit_config_status_regs

/* sim/fp_unit_model.sv */
// Behavioural model of the floating-point units that report warning flags
`timescale 1ns/10ps
module fp_unit_model (
  // Clock
  input  wire logic                   clock,
  // Flag reports to the register bank
  output fp_cfg_pkg::fp_event_t [1:0] adderEvt,
  output fp_cfg_pkg::fp_event_t [1:0] auxEvt,
  output fp_cfg_pkg::fp_event_t [1:0] mulEvt
);
  initial begin
    adderEvt <= '0;
    auxEvt   <= '0;
    mulEvt   <= '0;
  end

  task automatic put(input logic [1:0] unit, input logic side, input fp_cfg_pkg::fp_event_t ev);
    case (unit)
      2'h0: adderEvt[side] <= ev;
      2'h1: auxEvt[side] <= ev;
      default: mulEvt[side] <= ev;
    endcase
  endtask

  // One report lasts one cycle
  task automatic report(input logic [1:0] unit, input logic side, input logic cond,
                        input logic addSub, input logic [10:0] flags);
    fp_cfg_pkg::fp_event_t ev;
    ev = '{fire: 1'b1, condTrue: cond, addSub: addSub, flags: flags};
    @(posedge clock);
    put(unit, side, ev);
    @(posedge clock);
    // Idle flags hold the inverted pattern so a missing fire qualifier shows up
    ev.fire  = 1'b0;
    ev.flags = ~flags;
    put(unit, side, ev);
  endtask
endmodule // fp_unit_model

/* sim/tb_fp_unit_config_status_regs.sv */
// Testbench for the floating-point configuration and status registers
`timescale 1ns/10ps
module tb_fp_unit_config_status_regs;
  logic                        clock;
  logic                        arst_n;
  logic                        ce;
  logic                        wrEn;
  logic [1:0]                  wrSel;
  logic [31:0]                 wrData;
  logic                        rdEn;
  logic [1:0]                  rdSel;
  logic [31:0]                 rdData;
  logic                        rdValid;
  fp_cfg_pkg::fp_event_t [1:0] adderEvt;
  fp_cfg_pkg::fp_event_t [1:0] auxEvt;
  fp_cfg_pkg::fp_event_t [1:0] mulEvt;
  fp_cfg_pkg::round_t [1:0]    adderRound;
  fp_cfg_pkg::round_t [1:0]    auxAddRound;
  fp_cfg_pkg::round_t [1:0]    mulRound;
  logic [31:0]                 data;
  logic [1:0]                  vb;
  int                          nErrors = 0;
  int                          checked = 0;

  fp_unit_config_status_regs dut (.clock(clock), .arst_n(arst_n), .ce(ce), .wrEn(wrEn),
    .wrSel(wrSel), .wrData(wrData), .rdEn(rdEn), .rdSel(rdSel), .rdData(rdData),
    .rdValid(rdValid), .adderEvt(adderEvt), .auxEvt(auxEvt), .mulEvt(mulEvt),
    .adderRound(adderRound), .auxAddRound(auxAddRound), .mulRound(mulRound));
  fp_unit_model pm (.clock(clock), .adderEvt(adderEvt), .auxEvt(auxEvt), .mulEvt(mulEvt));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [1:0] sel, input logic [31:0] d);
    @(posedge clock);
    wrEn   <= 1'b1;
    wrSel  <= sel;
    wrData <= d;
    @(posedge clock);
    wrEn   <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] sel, input logic [31:0] exp);
    @(posedge clock);
    rdEn  <= 1'b1;
    rdSel <= sel;
    @(posedge clock);
    rdEn  <= 1'b0;
    #1;
    chk("rdValid", 32'h1, {31'h0, rdValid});
    chk("rdData", exp, rdData);
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    nErrors++;
    final_report();
  end

  initial begin
    {arst_n, ce, wrEn, wrSel, wrData, rdEn, rdSel} <= '0;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    ce     <= 1'b1;
    for (int s = 0; s < 4; s++) rd(2'(s), 32'h0000_0000);
    $display("test reset done");
    for (int v = 0; v < 4; v++) begin
      vb   = 2'(v);
      data = {5'h1F, vb, 9'h000, 5'h1F, ~vb, 9'h000};
      wr(fp_cfg_pkg::SEL_ADDER, data);
      wr(fp_cfg_pkg::SEL_MUL, ~data);
      #1;
      chk("adderRound", {28'h0, vb, ~vb}, {28'h0, adderRound[1], adderRound[0]});
      chk("auxAddRound", {28'h0, vb, ~vb}, {28'h0, auxAddRound[1], auxAddRound[0]});
      chk("mulRound", {28'h0, ~vb, vb}, {28'h0, mulRound[1], mulRound[0]});
      rd(fp_cfg_pkg::SEL_ADDER, data & 32'h07FF_07FF);
      rd(fp_cfg_pkg::SEL_MUL, ~data & 32'h07FF_07FF);
    end
    wr(fp_cfg_pkg::SEL_AUX, 32'hFFFF_FFFF);
    wr(2'h3, 32'h0000_0000);
    rd(fp_cfg_pkg::SEL_AUX, 32'h07FF_07FF);
    rd(2'h3, 32'h0000_0000);
    for (int s = 0; s < 3; s++) wr(2'(s), 32'h0000_0000);
    $display("test access done");
    for (int i = 0; i < 11; i++) pm.report(2'h1, i[0], 1'b1, 1'b0, 11'h1 << i);
    rd(fp_cfg_pkg::SEL_AUX, 32'h02AA_0555);
    pm.report(2'h2, 1'b1, 1'b1, 1'b0, 11'h7FF);
    pm.report(2'h2, 1'b0, 1'b1, 1'b0, 11'h7EF);
    pm.report(2'h0, 1'b1, 1'b1, 1'b0, 11'h0FF);
    pm.report(2'h0, 1'b0, 1'b1, 1'b0, 11'h090);
    rd(fp_cfg_pkg::SEL_MUL, 32'h017F_01EF);
    $display("test flags done");
    pm.report(2'h1, 1'b0, 1'b1, 1'b1, 11'h7C1);
    pm.report(2'h1, 1'b1, 1'b1, 1'b1, 11'h540);
    rd(fp_cfg_pkg::SEL_ADDER, 32'h017F_01D1);
    rd(fp_cfg_pkg::SEL_AUX, 32'h02AA_0555);
    pm.report(2'h1, 1'b1, 1'b0, 1'b0, 11'h7FF);
    pm.report(2'h0, 1'b0, 1'b0, 1'b0, 11'h7FF);
    rd(fp_cfg_pkg::SEL_AUX, 32'h02AA_0555);
    rd(fp_cfg_pkg::SEL_ADDER, 32'h017F_01D1);
    $display("test routing done");
    fork
      wr(fp_cfg_pkg::SEL_AUX, 32'hA5A5_5A5A);
      begin
        @(posedge clock);
        rd(fp_cfg_pkg::SEL_AUX, 32'h05A5_025A);
      end
    join
    wr(fp_cfg_pkg::SEL_AUX, 32'h0000_0000);
    rd(fp_cfg_pkg::SEL_AUX, 32'h0000_0000);
    @(posedge clock);
    ce <= 1'b0;
    fork
      wr(fp_cfg_pkg::SEL_AUX, 32'hFFFF_FFFF);
      pm.report(2'h1, 1'b0, 1'b1, 1'b0, 11'h7FF);
    join
    ce <= 1'b1;
    rd(fp_cfg_pkg::SEL_AUX, 32'h0000_0000);
    $display("test freeze done");
    fork
      wr(fp_cfg_pkg::SEL_MUL, 32'h0000_0600);
      pm.report(2'h2, 1'b0, 1'b1, 1'b0, 11'h041);
    join
    rd(fp_cfg_pkg::SEL_MUL, 32'h0000_0641);
    chk("mulRound", 32'h3, {30'h0, mulRound[0]});
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    rd(fp_cfg_pkg::SEL_MUL, 32'h0000_0000);
    chk("mulRound", 32'h0, {30'h0, mulRound[0]});
    $display("test sticky done");
    final_report();
  end
endmodule // tb_fp_unit_config_status_regs
